// *** axil_slave.sv ***
`timescale 1ns/1ps
module axil_slave
	import drv_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [3:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [3:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	ctrl_if.regs cif
);
	// ==========
	// write path: hold address and data until both taken
	logic aw_q, w_q;
	logic [3:0] awa_q;
	logic [31:0] wd_q;
	wire both = aw_q && w_q && !bvalid;
	wire hit = awa_q == ctrl_off;
	wire aw_take = awvalid && awready;
	wire w_take = wvalid && wready;
	wire aw_next = both ? 1'b0 : (aw_take ? 1'b1 : aw_q);
	wire w_next = both ? 1'b0 : (w_take ? 1'b1 : w_q);
	// wstrb is ignored: the enable and range always land as one whole word
	assign cif.wr = both && hit;
	assign cif.wdata = wd_q;
	// readies are flops holding the inverse of the next held flag, so no pin is combinational
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_q <= 1'b0;
			w_q <= 1'b0;
			awready <= 1'b0;
			wready <= 1'b0;
			awa_q <= 4'h0;
			wd_q <= 32'h0;
			bvalid <= 1'b0;
			bresp <= resp_okay;
		end else if (ce) begin
			aw_q <= aw_next;
			w_q <= w_next;
			awready <= !aw_next;
			wready <= !w_next;
			if (aw_take) begin
				awa_q <= awaddr;
			end
			if (w_take) begin
				wd_q <= wdata;
			end
			if (both) begin
				bvalid <= 1'b1;
				bresp <= hit ? resp_okay : resp_slverr;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end
	// ==========
	// read path
	wire [31:0] rd_mux = (araddr == ctrl_off) ? cif.ctrl :
		(araddr == stat_off) ? cif.status : 32'h0;
	wire rd_ok = araddr == ctrl_off || araddr == stat_off;
	wire ar_take = arvalid && arready;
	wire r_next = ar_take ? 1'b1 : ((rvalid && rready) ? 1'b0 : rvalid);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			arready <= 1'b0;
			rdata <= 32'h0;
			rresp <= resp_okay;
		end else if (ce) begin
			rvalid <= r_next;
			arready <= !r_next;
			if (ar_take) begin
				rdata <= rd_mux;
				rresp <= rd_ok ? resp_okay : resp_slverr;
			end
		end
	end
endmodule

// *** ctrl_if.sv ***
`timescale 1ns/1ps
interface ctrl_if;
	logic wr;
	logic [31:0] wdata;
	logic [31:0] ctrl;
	logic [31:0] status;
	modport regs (output wr, output wdata, input ctrl, input status);
	modport core (input wr, input wdata, output ctrl, output status);
endinterface

// *** drv_pkg.sv ***
package drv_pkg;
	// register byte offsets
	localparam logic [3:0] ctrl_off = 4'h0;
	localparam logic [3:0] stat_off = 4'h4;
	localparam logic [3:0] pins_off = 4'h8;
	// control register fields
	localparam int range_lsb = 4;
	localparam int range_w = 4;
	localparam int enable_bit = 0;
	localparam int clear_level_choice_bit = 1;
	localparam int soft_rst_bit = 2;
	localparam logic [31:0] ctrl_reset = 32'h0000_0000;
	localparam logic [31:0] ctrl_wmask = 32'h0000_00f3;
	// status register fields
	localparam int st_mode_bit = 0;
	localparam int st_ven_bit = 1;
	localparam int st_ien_bit = 2;
	localparam int st_vzero_bit = 3;
	localparam int st_clear_bit = 4;
	localparam int st_range_lsb = 8;
	localparam int st_kind_lsb = 12;
	// range codes
	localparam logic [3:0] rng_v5 = 4'h0;
	localparam logic [3:0] rng_v10 = 4'h1;
	localparam logic [3:0] rng_v40 = 4'h2;
	localparam logic [3:0] rng_i4_20 = 4'h4;
	localparam logic [3:0] rng_i0_20 = 4'h5;
	localparam logic [3:0] rng_i0_24 = 4'h6;
	localparam logic [1:0] resp_okay = 2'b00;
	localparam logic [1:0] resp_slverr = 2'b10;
	typedef enum logic [2:0] {
		range_none = 3'b001,
		range_volt = 3'b010,
		range_curr = 3'b100
	} range_kind_e;
	function automatic range_kind_e range_kind(input logic [3:0] code);
		if (code == rng_v5 || code == rng_v10 || code == rng_v40) begin
			return range_volt;
		end
		if (code == rng_i4_20 || code == rng_i0_20 || code == rng_i0_24) begin
			return range_curr;
		end
		return range_none;
	endfunction
endpackage

// *** drv_top.sv ***
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
module drv_top
	import drv_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic control_source_strap,
	input wire logic zero_force,
	input wire logic pin_drive_enable,
	input wire logic pin_clear_level_choice,
	input wire logic [3:0] pin_range_code,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic voltage_output_pin_en_q,
	output logic voltage_output_zero_q,
	output logic current_output_pin_en_q,
	output logic clear_level_q,
	output logic clear_level_sel_q,
	output logic [3:0] active_range_q,
	output logic hw_mode_q
);
	ctrl_if cif();
	logic zf_start, started;
	axil_slave u_bus (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.awaddr(s_axi_awaddr),
		.awvalid(s_axi_awvalid),
		.awready(s_axi_awready),
		.wdata(s_axi_wdata),
		.wstrb(s_axi_wstrb),
		.wvalid(s_axi_wvalid),
		.wready(s_axi_wready),
		.bresp(s_axi_bresp),
		.bvalid(s_axi_bvalid),
		.bready(s_axi_bready),
		.araddr(s_axi_araddr),
		.arvalid(s_axi_arvalid),
		.arready(s_axi_arready),
		.rdata(s_axi_rdata),
		.rresp(s_axi_rresp),
		.rvalid(s_axi_rvalid),
		.rready(s_axi_rready),
		.cif(cif.regs)
	);
	mode_latch u_mode (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.strap(control_source_strap),
		.zero_force(zero_force),
		.hw_mode_q(hw_mode_q),
		.zf_at_start_q(zf_start),
		.done_q(started)
	);
	// ==========
	// control register (software mode)
	logic [31:0] ctrl_q;
	assign cif.ctrl = ctrl_q;
	// a reset bit clears the whole control register and itself, so it never reads back set
	wire soft_rst = cif.wr && cif.wdata[soft_rst_bit];
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= ctrl_reset;
		end else if (ce) begin
			if (soft_rst || hw_mode_q) begin
				ctrl_q <= ctrl_reset;
			end else if (cif.wr) begin
				ctrl_q <= cif.wdata & ctrl_wmask;
			end
		end
	end
	// ==========
	// selection of source per mode
	wire [3:0] range_sel = hw_mode_q ? pin_range_code : ctrl_q[range_lsb +: range_w];
	wire en_sel = hw_mode_q ? (pin_drive_enable && !zero_force) : ctrl_q[enable_bit];
	wire clr_sel = hw_mode_q ? pin_clear_level_choice : ctrl_q[clear_level_choice_bit];
	range_kind_e kind;
	assign kind = range_kind(range_sel);
	wire want_v = en_sel && kind == range_volt;
	wire want_i = en_sel && kind == range_curr;
	// power-up zero drive holds only until the first enabling write or soft reset write
	logic pre_en_q;
	wire zero_drive = !hw_mode_q && pre_en_q && zf_start;
	logic [31:0] status;
	always_comb begin
		status = 32'h0;
		status[st_mode_bit] = hw_mode_q;
		status[st_ven_bit] = voltage_output_pin_en_q;
		status[st_ien_bit] = current_output_pin_en_q;
		status[st_vzero_bit] = voltage_output_zero_q;
		status[st_clear_bit] = zero_force;
		status[st_range_lsb +: range_w] = range_sel;
		status[st_kind_lsb +: $bits(range_kind_e)] = kind;
	end
	assign cif.status = status;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pre_en_q <= 1'b1;
			voltage_output_pin_en_q <= 1'b0;
			voltage_output_zero_q <= 1'b0;
			current_output_pin_en_q <= 1'b0;
			clear_level_q <= 1'b0;
			clear_level_sel_q <= 1'b0;
			active_range_q <= 4'h0;
		end else if (ce) begin
			if (en_sel || soft_rst) begin
				pre_en_q <= 1'b0;
			end
			if (!started) begin
				voltage_output_pin_en_q <= 1'b0;
				current_output_pin_en_q <= 1'b0;
				voltage_output_zero_q <= 1'b0;
			end else if (en_sel) begin
				voltage_output_pin_en_q <= want_v;
				current_output_pin_en_q <= want_i && !want_v;
				voltage_output_zero_q <= 1'b0;
			end else begin
				voltage_output_pin_en_q <= zero_drive;
				current_output_pin_en_q <= 1'b0;
				voltage_output_zero_q <= zero_drive;
			end
			clear_level_q <= started && en_sel && zero_force;
			clear_level_sel_q <= clr_sel;
			active_range_q <= range_sel;
		end
	end
	// ==========
	a_one_channel: assert property (@(posedge aclk) disable iff (!aresetn)
		!(voltage_output_pin_en_q && current_output_pin_en_q)) else $error("both channels on");
	a_disabled_hiz: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && started && !en_sel && !zero_drive |=> !voltage_output_pin_en_q && !current_output_pin_en_q)
		else $error("disabled output not high impedance");
	a_clear_follows: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && started && en_sel && zero_force |=> clear_level_q) else $error("clear level missed");
	a_mode_fixed: assert property (@(posedge aclk) disable iff (!aresetn)
		started && $past(started) |-> $stable(hw_mode_q)) else $error("mode changed");
	a_soft_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(started) && !hw_mode_q && !en_sel ##0 ce && zf_start |=> voltage_output_zero_q)
		else $error("zero drive missing");
	a_soft_hiz: assert property (@(posedge aclk) disable iff (!aresetn)
		started && !hw_mode_q && !zf_start && !ctrl_q[enable_bit] |=> !voltage_output_pin_en_q)
		else $error("voltage not high impedance");
	a_current_off: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(started) ##1 !hw_mode_q && !ctrl_q[enable_bit] |-> !current_output_pin_en_q)
		else $error("current channel on at start");
	a_range_src: assert property (@(posedge aclk) disable iff (!aresetn)
		ce |=> active_range_q == $past(range_sel)) else $error("range source wrong");
	a_ctrl_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(started) && !hw_mode_q |-> ctrl_q == ctrl_reset) else $error("control not zero");
	a_hw_ignore: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && hw_mode_q |=> ctrl_q == ctrl_reset) else $error("control written in hardware mode");
	a_hw_disabled: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && started && hw_mode_q && !(pin_drive_enable && !zero_force)
		|=> !voltage_output_pin_en_q && !current_output_pin_en_q) else $error("hardware disable ignored");
endmodule

// *** host_model.sv ***
`timescale 1ns/1ps
// ==========
// host side master, one write and one read at most in flight
module host_model (
	input wire logic aclk,
	output logic [3:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready,
	output logic [3:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic rready
);
	initial begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
	end
	// enable and range always travel in the same word
	task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		{awvalid, wvalid, bready} <= 3'b111;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
		wdata <= ~d;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		{arvalid, rready} <= 2'b11;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
endmodule

// *** mode_latch.sv ***
`timescale 1ns/1ps
module mode_latch (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic strap,
	input wire logic zero_force,
	output logic hw_mode_q,
	output logic zf_at_start_q,
	output logic done_q
);
	// ==========
	// strap caught on first enabled edge after release, then frozen
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hw_mode_q <= 1'b0;
			zf_at_start_q <= 1'b0;
			done_q <= 1'b0;
		end else if (ce && !done_q) begin
			hw_mode_q <= strap;
			zf_at_start_q <= zero_force;
			done_q <= 1'b1;
		end
	end
endmodule

// *** tb_top.sv ***
`timescale 1ns/1ps
// ==========
module tb_top;
	import drv_pkg::*;
	logic aclk = 0, aresetn = 0, strap = 0, zf = 0, pen = 0, ce = 1, pclr = 0;
	logic [3:0] prng = 4'h0;
	logic [3:0] awaddr, araddr, wstrb, rng_q;
	logic [31:0] wdata, rdata, rd;
	logic [1:0] bresp, rresp, resp;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic v_en, v_zero, i_en, clr, clr_sel, hw;
	int n_fail = 0, n_tests = 0;
	// row: range code, voltage en, current en, kind
	logic [8:0] rows [8] = '{{rng_v5, 2'b10, 3'b010}, {rng_v10, 2'b10, 3'b010}, {rng_v40, 2'b10, 3'b010},
		{4'h3, 2'b00, 3'b001}, {rng_i4_20, 2'b01, 3'b100}, {rng_i0_20, 2'b01, 3'b100},
		{rng_i0_24, 2'b01, 3'b100}, {4'hf, 2'b00, 3'b001}};
	always #5 aclk = ~aclk;
	drv_top i_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .control_source_strap(strap), .zero_force(zf),
		.pin_drive_enable(pen), .pin_clear_level_choice(pclr), .pin_range_code(prng),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .voltage_output_pin_en_q(v_en), .voltage_output_zero_q(v_zero),
		.current_output_pin_en_q(i_en), .clear_level_q(clr), .clear_level_sel_q(clr_sel),
		.active_range_q(rng_q), .hw_mode_q(hw));
	host_model i_host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic stop_test;
		if (n_fail == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// strap and zero force are set up while reset is held
	task automatic restart(input logic s, input logic z);
		@(posedge aclk);
		aresetn <= 1'b0;
		strap <= s;
		zf <= z;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (4) @(posedge aclk);
		#1;
	endtask
	// control change lands on the edge that raises the response, outputs one edge later
	task automatic settle;
		repeat (2) @(posedge aclk);
		#1;
	endtask
	initial begin
		#20us;
		n_fail++;
		stop_test();
	end
	initial begin
		restart(1'b0, 1'b0);
		chk({v_en, v_zero, i_en, clr, hw}, 5'b00000);
		i_host.rd(ctrl_off, rd, resp);
		chk(rd, ctrl_reset);
		for (int k = 0; k < 8; k++) begin
			i_host.wr(ctrl_off, {24'h0, rows[k][8:5], 4'h1}, resp);
			settle();
			chk({v_en, i_en}, rows[k][4:3]);
			chk(rng_q, rows[k][8:5]);
			i_host.rd(stat_off, rd, resp);
			chk(rd[14:12], rows[k][2:0]);
		end
		i_host.wr(ctrl_off, {24'h0, rng_v10, 4'h2}, resp);
		settle();
		chk({v_en, i_en, clr_sel}, 3'b001);
		i_host.wr(stat_off, 32'hffff_ffff, resp);
		chk(resp, resp_slverr);
		i_host.rd(pins_off, rd, resp);
		chk({rd, resp}, {32'h0, resp_slverr});
		restart(1'b0, 1'b1);
		chk({v_zero, i_en}, 2'b10);
		i_host.wr(ctrl_off, {24'h0, rng_i0_20, 4'h1}, resp);
		settle();
		chk({clr, i_en, v_en, v_zero}, 4'b1100);
		@(posedge aclk) zf <= 1'b0;
		settle();
		chk(clr, 1'b0);
		i_host.wr(ctrl_off, {24'h0, rng_i0_20, 4'h5}, resp);
		settle();
		chk({v_en, v_zero, i_en}, 3'b000);
		i_host.rd(ctrl_off, rd, resp);
		chk(rd, ctrl_reset);
		@(posedge aclk) prng <= rng_v10;
		pen <= 1'b0;
		pclr <= 1'b1;
		restart(1'b1, 1'b0);
		chk({hw, v_en, i_en, clr_sel, rng_q}, {4'b1001, rng_v10});
		@(posedge aclk) pen <= 1'b1;
		strap <= 1'b0;
		settle();
		chk({hw, v_en, i_en}, 3'b110);
		@(posedge aclk) prng <= rng_i0_24;
		settle();
		chk({v_en, i_en, rng_q}, {2'b01, rng_i0_24});
		i_host.wr(ctrl_off, {24'h0, rng_v5, 4'h1}, resp);
		i_host.rd(ctrl_off, rd, resp);
		chk(rd, ctrl_reset);
		@(posedge aclk) zf <= 1'b1;
		settle();
		chk({v_en, i_en}, 2'b00);
		@(posedge aclk) ce <= 1'b0;
		zf <= 1'b0;
		settle();
		chk({v_en, i_en}, 2'b00);
		@(posedge aclk) ce <= 1'b1;
		settle();
		chk({v_en, i_en}, 2'b01);
		stop_test();
	end
endmodule
